/* hw/cplsc_top.sv */
// Function
// - Sleep request in stop-grant enters sleep.
// - Sleep gates every unit clock off.
// - Sleep ignores snoops and interrupts.
// - Sleep reacts only to reset, sleep, deep-sleep, bus clock loss.
// - Sleep release returns to stop-grant, bus and irq_unit clocks restart.
// - Bus clock stop or deep request enters deep-sleep.
// - Accepted management interrupt saves state, enters mode.
// - Issue management acknowledge, then start handler.
// - Management interrupt at reset release disables outputs.
// - Clock halt request enters stop-grant from running.
// - Stop-grant entry issues stop-grant acknowledge.
// - Stop-grant stops core, keeps bus, irq_unit.
// - Stop-grant keeps snooping and servicing interrupts.
// - Halt release restarts all clocks, resumes execution.
// - Clock halt is asynchronous, bus clock untouched.
// - Socket presence output is tied low.
`include "cplsc_cfg.svh"

module cplsc_top
  import cplsc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clock_halt_req_n,
  input wire logic sleep_req_n,
  input wire logic deep_sleep_req_n,
  input wire logic mgmt_irq_n,
  input wire logic bus_clk_present,
  input wire logic snoop_req,
  input wire logic irq_req,
  input wire logic ack_ready,
  input wire logic mgmt_resume,
  output logic ack_valid,
  output cplsc_ack_t ack_kind,
  output cplsc_clk_en_t clk_en,
  output logic snoop_take,
  output logic irq_take,
  output logic state_save,
  output logic handler_start,
  output logic mgmt_mode,
  output logic exec_run,
  output logic pin_drive_en,
  output logic socket_present_n,
  output cplsc_state_t pm_state
);

  cplsc_side_t side_raw;
  cplsc_side_t side;
  cplsc_state_t state_r;
  cplsc_state_t state_nxt;
  cplsc_mseq_t mseq_r;
  cplsc_mseq_t mseq_nxt;
  logic halt;
  logic sleep;
  logic deep;
  logic bclk_ok;
  logic mgmt_prev_r;
  logic mgmt_edge;
  logic mgmt_pend_r;
  logic mgmt_accept;
  logic [1:0] strap_cnt_r;
  logic strap_done_r;
  logic hiz_r;
  logic ack_pend_r;
  logic ack_done;
  logic sg_ack_pend;
  logic enter_sg;

  ////////////////////////////////////////////////////////////////////////
  // Sideband pins are asynchronous to the bus clock; they are only
  // sampled here, so the bus clock itself is never touched.
  assign side_raw = '{clock_halt_req_n, sleep_req_n, deep_sleep_req_n,
                      mgmt_irq_n, bus_clk_present};

  cplsc_sync #(
    .W(5)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d(side_raw),
    .q(side)
  );

  // Active-high views of the synchronised requests.
  assign halt = !side.clock_halt_req_n;
  assign sleep = !side.sleep_req_n;
  assign deep = !side.deep_sleep_req_n;
  assign bclk_ok = side.bus_clk_present;

  ////////////////////////////////////////////////////////////////////////
  // Strap capture: the management pin level is taken a few cycles after
  // release, once the synchroniser holds real pin values.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'h0;
      hiz_r <= 1'h0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == `CPLSC_STRAP_WAIT) begin
        strap_done_r <= 1'h1;
        hiz_r <= !side.mgmt_irq_n;
      end else begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end
  end

  // Outputs stay released until the strap is known, so a tristating
  // part never glitches onto the bus.
  assign pin_drive_en = strap_done_r && !hiz_r;

  // Tie-low presence output for board detection.
  assign socket_present_n = 1'h0;

  ////////////////////////////////////////////////////////////////////////
  // Management interrupt request latch; a new edge beats the clear.
  assign mgmt_edge = mgmt_prev_r && !side.mgmt_irq_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mgmt_prev_r <= 1'h1;
    end else begin
      mgmt_prev_r <= side.mgmt_irq_n;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mgmt_pend_r <= 1'h0;
    end else if (mgmt_edge && strap_done_r) begin
      mgmt_pend_r <= 1'h1;
    end else if (mgmt_accept) begin
      mgmt_pend_r <= 1'h0;
    end
  end

  // Requests are only accepted while executing and not already inside
  // the management mode; a request during low power waits for wake-up.
  assign mgmt_accept = mgmt_pend_r && pin_drive_en && !mgmt_mode &&
                       (state_r == CPLSC_RUN) && (mseq_r == CPLSC_M_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge port towards the bus unit.
  assign ack_valid = ack_pend_r && pin_drive_en;
  assign ack_done = ack_valid && ack_ready;
  assign sg_ack_pend = ack_pend_r && (ack_kind == CPLSC_ACK_STOPGRANT);
  assign enter_sg = (state_r == CPLSC_RUN) &&
                    (state_nxt == CPLSC_STOPGRANT);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_pend_r <= 1'h0;
      ack_kind <= CPLSC_ACK_STOPGRANT;
    end else if (enter_sg) begin
      ack_pend_r <= 1'h1;
      ack_kind <= CPLSC_ACK_STOPGRANT;
    end else if (mseq_r == CPLSC_M_SAVE) begin
      ack_pend_r <= 1'h1;
      ack_kind <= CPLSC_ACK_MGMT;
    end else if (ack_done) begin
      ack_pend_r <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Management entry sequence: save, acknowledge, then handler.
  always_comb begin
    mseq_nxt = mseq_r;
    case (mseq_r)
      CPLSC_M_IDLE: begin
        if (mgmt_accept) begin
          mseq_nxt = CPLSC_M_SAVE;
        end
      end
      CPLSC_M_SAVE: begin
        mseq_nxt = CPLSC_M_ACK;
      end
      CPLSC_M_ACK: begin
        if (ack_done) begin
          mseq_nxt = CPLSC_M_IDLE;
        end
      end
      default: begin
        mseq_nxt = CPLSC_M_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mseq_r <= CPLSC_M_IDLE;
    end else begin
      mseq_r <= mseq_nxt;
    end
  end

  // Save strobe, handler start strobe and the mode flag.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_save <= 1'h0;
      handler_start <= 1'h0;
      mgmt_mode <= 1'h0;
    end else begin
      state_save <= mgmt_accept;
      handler_start <= ack_done && (ack_kind == CPLSC_ACK_MGMT);
      if (mgmt_accept) begin
        mgmt_mode <= 1'h1;
      end else if (mgmt_resume && (mseq_r == CPLSC_M_IDLE)) begin
        mgmt_mode <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state machine. Stop-grant is held until its acknowledge has
  // gone out, so the chipset never sees a sleep without the grant.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CPLSC_RUN: begin
        if (halt && !mgmt_accept && (mseq_r == CPLSC_M_IDLE)) begin
          state_nxt = CPLSC_STOPGRANT;
        end
      end
      CPLSC_STOPGRANT: begin
        if (!sg_ack_pend) begin
          if (!halt) begin
            state_nxt = CPLSC_RUN;
          end else if (sleep) begin
            state_nxt = CPLSC_SLEEP;
          end
        end
      end
      CPLSC_SLEEP: begin
        // Only sleep, deep-sleep and bus clock loss are looked at.
        if (!sleep) begin
          state_nxt = CPLSC_STOPGRANT;
        end else if (deep || !bclk_ok) begin
          state_nxt = CPLSC_DEEPSLEEP;
        end
      end
      CPLSC_DEEPSLEEP: begin
        if (!deep && bclk_ok) begin
          state_nxt = CPLSC_SLEEP;
        end
      end
      default: begin
        state_nxt = CPLSC_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= CPLSC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Clock enables follow the next state so they switch with it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_en <= `CPLSC_CLKEN_RUN;
    end else begin
      case (state_nxt)
        CPLSC_RUN: clk_en <= `CPLSC_CLKEN_RUN;
        CPLSC_STOPGRANT: clk_en <= `CPLSC_CLKEN_STOPGRANT;
        CPLSC_SLEEP: clk_en <= `CPLSC_CLKEN_SLEEP;
        default: clk_en <= `CPLSC_CLKEN_SLEEP;
      endcase
    end
  end

  // Snoops need the bus clock running, interrupts the irq_unit clock.
  assign snoop_take = snoop_req && clk_en.bus;
  assign irq_take = irq_req && clk_en.irq_unit;
  assign exec_run = (state_r == CPLSC_RUN);
  assign pm_state = state_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_sleep_entry: assert property (
    state_r == CPLSC_STOPGRANT && halt && sleep && !sg_ack_pend
    |=> state_r == CPLSC_SLEEP)
    else $error("sleep not entered from stop-grant");

  chk_sleep_clocks: assert property (
    state_r == CPLSC_SLEEP || state_r == CPLSC_DEEPSLEEP
    |-> clk_en == `CPLSC_CLKEN_SLEEP)
    else $error("clocks running in sleep");

  chk_sleep_deaf: assert property (
    state_r == CPLSC_SLEEP |-> !snoop_take && !irq_take)
    else $error("snoop or interrupt taken in sleep");

  chk_sleep_hold: assert property (
    state_r == CPLSC_SLEEP && sleep && !deep && bclk_ok
    |=> state_r == CPLSC_SLEEP)
    else $error("sleep left without a wake event");

  chk_sleep_exit: assert property (
    state_r == CPLSC_SLEEP && !sleep
    |=> state_r == CPLSC_STOPGRANT && clk_en.bus)
    else $error("sleep release did not reach stop-grant");

  chk_deep_entry: assert property (
    state_r == CPLSC_SLEEP && sleep && (deep || !bclk_ok)
    |=> state_r == CPLSC_DEEPSLEEP)
    else $error("deep-sleep not entered");

  chk_mgmt_save: assert property (
    mgmt_accept |=> state_save && mgmt_mode ##1 ack_valid)
    else $error("management entry did not save state");

  chk_mgmt_ack: assert property (
    $rose(handler_start) |-> $past(ack_done) &&
    $past(ack_kind) == CPLSC_ACK_MGMT)
    else $error("handler started without acknowledge");

  chk_hiz_strap: assert property (
    strap_done_r && hiz_r |-> !pin_drive_en && !ack_valid)
    else $error("outputs driven after tristate strap");

  chk_halt_entry: assert property (
    state_r == CPLSC_RUN && halt && !mgmt_accept &&
    mseq_r == CPLSC_M_IDLE |=> state_r == CPLSC_STOPGRANT)
    else $error("clock halt did not enter stop-grant");

  chk_sg_ack: assert property (
    state_r == CPLSC_RUN ##1 state_r == CPLSC_STOPGRANT
    |-> ack_pend_r && ack_kind == CPLSC_ACK_STOPGRANT)
    else $error("stop-grant acknowledge missing");

  chk_sg_clocks: assert property (
    state_r == CPLSC_STOPGRANT
    |-> !clk_en.core && clk_en.bus && clk_en.irq_unit)
    else $error("wrong clocks in stop-grant");

  chk_sg_snoop: assert property (
    state_r == CPLSC_STOPGRANT && snoop_req && irq_req
    |-> snoop_take && irq_take)
    else $error("stop-grant dropped snoop or interrupt");

  chk_resume_run: assert property (
    state_r == CPLSC_STOPGRANT && !halt && !sg_ack_pend
    |=> exec_run && clk_en == `CPLSC_CLKEN_RUN)
    else $error("halt release did not resume");

  chk_socket_low: assert property (
    socket_present_n == 1'h0)
    else $error("presence output not low");

  cov_deep_sleep: cover property (
    state_r == CPLSC_SLEEP ##1 state_r == CPLSC_DEEPSLEEP);

  cov_mgmt_entry: cover property (
    mgmt_accept ##[1:20] handler_start);

  cov_sg_round: cover property (
    state_r == CPLSC_STOPGRANT ##[1:50] state_r == CPLSC_RUN);

endmodule // cplsc_top

/* hw/cplsc_cfg.svh */
`ifndef CPLSC_CFG_SVH
`define CPLSC_CFG_SVH

// Clock enable patterns, ordered {core, bus, irq_unit}.
`define CPLSC_CLKEN_RUN 3'h7
`define CPLSC_CLKEN_STOPGRANT 3'h3
`define CPLSC_CLKEN_SLEEP 3'h0

// Reset value of every synchroniser flop: all sideband inputs idle high.
`define CPLSC_SYNC_RST 1'h1

// Cycles after reset release before the strap is caught; covers two
// synchroniser stages plus one settle cycle.
`define CPLSC_STRAP_WAIT 2'h3

`endif

/* hw/cplsc_pkg.sv */
package cplsc_pkg;

  // Power state of the processor.
  typedef enum logic [1:0] {
    CPLSC_RUN,
    CPLSC_STOPGRANT,
    CPLSC_SLEEP,
    CPLSC_DEEPSLEEP
  } cplsc_state_t;

  // Progress of a management interrupt entry.
  typedef enum logic [1:0] {
    CPLSC_M_IDLE,
    CPLSC_M_SAVE,
    CPLSC_M_ACK
  } cplsc_mseq_t;

  // Kind of acknowledge transaction offered to the bus unit.
  typedef enum logic {
    CPLSC_ACK_STOPGRANT,
    CPLSC_ACK_MGMT
  } cplsc_ack_t;

  // Internal clock enables, one per unit group.
  typedef struct packed {
    logic core;
    logic bus;
    logic irq_unit;
  } cplsc_clk_en_t;

  // Synchronised sideband levels, as on the pins.
  typedef struct packed {
    logic clock_halt_req_n;
    logic sleep_req_n;
    logic deep_sleep_req_n;
    logic mgmt_irq_n;
    logic bus_clk_present;
  } cplsc_side_t;

endpackage

/* hw/cplsc_sync.sv */
`include "cplsc_cfg.svh"

// Two-stage level synchroniser; only the second stage is visible.
module cplsc_sync #(
  parameter int W = 5
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  ////////////////////////////////////////////////////////////////////////
  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {W{`CPLSC_SYNC_RST}};
      q <= {W{`CPLSC_SYNC_RST}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // cplsc_sync

/* dv/cplsc_chipset.sv */
////////////////////////////////////////////////////////////////////////
// Chipset model: drives the sideband request pins of the processor.
module cplsc_chipset
  import cplsc_pkg::*;
(
  input wire logic mclk,
  output cplsc_side_t side
);
  timeunit 1ns;
  timeprecision 1ps;

  // All requests idle high and the bus clock runs from time zero.
  initial begin
    side = '1;
  end

  // New pin levels land just after an edge and then hold.
  task automatic request(input cplsc_side_t v);
    @(posedge mclk);
    side <= v;
  endtask

  // The interrupt pin is pulsed with no regard to the core's state.
  task automatic pulse_mgmt();
    @(posedge mclk);
    side.mgmt_irq_n <= 1'h0;
    repeat (4) @(posedge mclk);
    side.mgmt_irq_n <= 1'h1;
  endtask
endmodule // cplsc_chipset

/* dv/tb_top.sv */
////////////////////////////////////////////////////////////////////////
// Self-checking bench for the power-state controller.
module tb_top
  import cplsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, nrst, snoop_req, irq_req, ack_ready, mgmt_resume;
  logic ack_valid, snoop_take, irq_take, state_save, handler_start;
  logic mgmt_mode, exec_run, pin_drive_en, socket_present_n;
  cplsc_ack_t ack_kind;
  cplsc_clk_en_t clk_en;
  cplsc_state_t pm_state;
  cplsc_side_t side, s;
  int fails = 0;
  int cmp_count = 0;

  cplsc_chipset u_cs (.mclk(mclk), .side(side));

  cplsc_top uut (
    .mclk(mclk), .nrst(nrst),
    .clock_halt_req_n(side.clock_halt_req_n),
    .sleep_req_n(side.sleep_req_n),
    .deep_sleep_req_n(side.deep_sleep_req_n),
    .mgmt_irq_n(side.mgmt_irq_n),
    .bus_clk_present(side.bus_clk_present),
    .snoop_req(snoop_req), .irq_req(irq_req), .ack_ready(ack_ready),
    .mgmt_resume(mgmt_resume), .ack_valid(ack_valid), .ack_kind(ack_kind),
    .clk_en(clk_en), .snoop_take(snoop_take), .irq_take(irq_take),
    .state_save(state_save), .handler_start(handler_start),
    .mgmt_mode(mgmt_mode), .exec_run(exec_run),
    .pin_drive_en(pin_drive_en), .socket_present_n(socket_present_n),
    .pm_state(pm_state)
  );

  ////////////////////////////////////////////////////////////////////////
  // Free-running bus clock, 20 ns period.
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Moves one settled point past the next n edges.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Sideband changes need sync plus one edge, so 8 edges is ample.
  task automatic wait_state(input cplsc_state_t st);
    for (int i = 0; i < 8 && pm_state !== st; i++) tick(1);
    chk({6'h0, pm_state}, {6'h0, st});
  endtask

  // The acknowledge is held by the design until taken, then drops.
  task automatic take_ack(input cplsc_ack_t k);
    for (int i = 0; i < 12 && ack_valid !== 1'h1; i++) tick(1);
    chk({7'h0, ack_kind}, {7'h0, k});
    @(posedge mclk);
    ack_ready <= 1'h1;
    @(posedge mclk);
    ack_ready <= 1'h0;
    #1;
    chk({7'h0, ack_valid}, 8'h0);
  endtask

  // Pins are set to s while reset is low, so release sees them settled.
  task automatic do_reset();
    @(posedge mclk);
    nrst <= 1'h0;
    u_cs.request(s);
    tick(11);
    chk({5'h0, clk_en}, 8'h07);
    @(posedge mclk);
    nrst <= 1'h1;
    tick(8);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({6'h0, pm_state}, 8'h00);
    chk({5'h0, clk_en}, 8'h07);
    chk({7'h0, socket_present_n}, 8'h00);
    chk({7'h0, pin_drive_en}, 8'h01);
    chk({7'h0, exec_run}, 8'h01);
  endtask

  task automatic t_halt();
    s.clock_halt_req_n = 1'h0;
    u_cs.request(s);
    wait_state(CPLSC_STOPGRANT);
    chk({5'h0, clk_en}, 8'h03);
    chk({7'h0, exec_run}, 8'h00);
    @(posedge mclk);
    snoop_req <= 1'h1;
    irq_req <= 1'h1;
    #1;
    chk({6'h0, snoop_take, irq_take}, 8'h03);
    take_ack(CPLSC_ACK_STOPGRANT);
  endtask

  // Walks sleep and deep sleep in both directions with requests held.
  task automatic t_sleep();
    s.sleep_req_n = 1'h0;
    u_cs.request(s);
    wait_state(CPLSC_SLEEP);
    chk({5'h0, clk_en}, 8'h00);
    chk({6'h0, snoop_take, irq_take}, 8'h00);
    s.clock_halt_req_n = 1'h1;
    u_cs.request(s);
    tick(6);
    chk({6'h0, pm_state}, 8'h02);
    s.clock_halt_req_n = 1'h0;
    s.bus_clk_present = 1'h0;
    u_cs.request(s);
    wait_state(CPLSC_DEEPSLEEP);
    s.bus_clk_present = 1'h1;
    u_cs.request(s);
    wait_state(CPLSC_SLEEP);
    s.deep_sleep_req_n = 1'h0;
    u_cs.request(s);
    wait_state(CPLSC_DEEPSLEEP);
    s.deep_sleep_req_n = 1'h1;
    u_cs.request(s);
    wait_state(CPLSC_SLEEP);
    s.sleep_req_n = 1'h1;
    u_cs.request(s);
    wait_state(CPLSC_STOPGRANT);
    chk({5'h0, clk_en}, 8'h03);
    s.clock_halt_req_n = 1'h1;
    u_cs.request(s);
    wait_state(CPLSC_RUN);
    chk({5'h0, clk_en}, 8'h07);
    @(posedge mclk);
    snoop_req <= 1'h0;
    irq_req <= 1'h0;
  endtask

  task automatic t_mgmt();
    fork
      u_cs.pulse_mgmt();
    join_none
    for (int i = 0; i < 10 && state_save !== 1'h1; i++) tick(1);
    chk({6'h0, state_save, mgmt_mode}, 8'h03);
    take_ack(CPLSC_ACK_MGMT);
    for (int i = 0; i < 3 && handler_start !== 1'h1; i++) tick(1);
    chk({7'h0, handler_start}, 8'h01);
    @(posedge mclk);
    mgmt_resume <= 1'h1;
    @(posedge mclk);
    mgmt_resume <= 1'h0;
    tick(2);
    chk({7'h0, mgmt_mode}, 8'h00);
  endtask

  // Reset taken while in sleep (not deep-sleep) must bring back all clocks.
  task automatic t_rst_sleep();
    s.clock_halt_req_n = 1'h0;
    u_cs.request(s);
    take_ack(CPLSC_ACK_STOPGRANT);
    s.sleep_req_n = 1'h0;
    u_cs.request(s);
    wait_state(CPLSC_SLEEP);
    s = '1;
    do_reset();
    chk({6'h0, pm_state}, 8'h00);
  endtask

  // Management pin held low across release leaves outputs floating.
  task automatic t_tristate();
    s.mgmt_irq_n = 1'h0;
    do_reset();
    chk({7'h0, pin_drive_en}, 8'h00);
    // A halt still moves the state, but its acknowledge must stay off.
    s.clock_halt_req_n = 1'h0;
    u_cs.request(s);
    wait_state(CPLSC_STOPGRANT);
    tick(20);
    chk({6'h0, pin_drive_en, ack_valid}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence; reset is held for 12 edges first.
  initial begin
    nrst = 1'h0;
    snoop_req = 1'h0;
    irq_req = 1'h0;
    ack_ready = 1'h0;
    mgmt_resume = 1'h0;
    s = '1;
    repeat (12) @(posedge mclk);
    nrst <= 1'h1;
    tick(8);
    t_reset();
    t_halt();
    t_sleep();
    t_mgmt();
    t_rst_sleep();
    t_tristate();
    give_verdict();
  end

  // Whole run needs well under 1000 cycles; cut a hang at 3000.
  initial begin
    #60000;
    fails++;
    give_verdict();
  end
endmodule // tb_top
